// file: core/ssp_defines.svh
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// Register indices; byte address is four times the index
`define SSP_IDX_CTRL      4'ha
`define SSP_IDX_STAT      4'hb
`define SSP_IDX_DATA      4'hc

// Control field positions and reset value
`define SSP_CTRL_EN       6
`define SSP_CTRL_MSTR     4
`define SSP_CTRL_IDLE_CLOCK_LEVEL_BIT     2
`define SSP_CTRL_MASK     8'h54
`define SSP_CTRL_RESET    8'h04

// Status field positions
`define SSP_STAT_DONE     7
`define SSP_STAT_CLASH    6

// Transfer size and master shift clock divide ratio
`define SSP_BITS          8
`define SSP_MASTER_DIV    4
// Shift clock edges per master transfer
`define SSP_MASTER_EDGES  16

`endif

// file: core/ssp_pkg.sv
package ssp_pkg;

  typedef enum logic [1:0] {
    SSP_BUS_IDLE = 2'b01,
    SSP_BUS_ACK  = 2'b10
  } ssp_bus_state_t;

  typedef enum logic [1:0] {
    SSP_CLK_IDLE = 2'b01,
    SSP_CLK_RUN  = 2'b10
  } ssp_clk_state_t;

endpackage : ssp_pkg

// file: core/ssp_clkgen.sv
`timescale 1ns/10ps
`default_nettype none
`include "ssp_defines.svh"

module ssp_clkgen
  import ssp_pkg::*;
#(
  parameter int DIV   = `SSP_MASTER_DIV,
  parameter int EDGES = `SSP_MASTER_EDGES
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic start_i,
  input  wire logic abort_i,
  input  wire logic idle_level_i,
  // Shift clock
  output logic      sck_o,
  output logic      rise_o,
  output logic      fall_o,
  output logic      busy_o
);

  localparam logic [7:0] HALF_C  = 8'(DIV / 2);
  localparam logic [5:0] EDGES_C = 6'(EDGES);

  ssp_clk_state_t state;
  logic [7:0]     phase;
  logic [5:0]     edges;
  logic           flip;

  assign flip   = (state == SSP_CLK_RUN) && (phase == HALF_C - 8'h01);
  assign rise_o = flip && !sck_o;
  assign fall_o = flip && sck_o;
  assign busy_o = (state == SSP_CLK_RUN);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= SSP_CLK_IDLE;
      phase <= 8'h00;
      edges <= 6'h00;
    end else begin
      case (state)
        SSP_CLK_IDLE: begin
          phase <= 8'h00;
          edges <= 6'h00;
          if (start_i && !abort_i) begin
            state <= SSP_CLK_RUN;
          end
        end
        SSP_CLK_RUN: begin
          if (abort_i) begin
            state <= SSP_CLK_IDLE;
          end else if (flip) begin
            phase <= 8'h00;
            edges <= edges + 6'h01;
            if (edges == EDGES_C - 6'h01) begin
              state <= SSP_CLK_IDLE;
            end
          end else begin
            phase <= phase + 8'h01;
          end
        end
        default: state <= SSP_CLK_IDLE;
      endcase
    end
  end

  // Idle level follows polarity; toggles every half period of DIV clocks
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_o <= 1'b1;
    end else if (state != SSP_CLK_RUN || abort_i) begin
      sck_o <= idle_level_i;
    end else if (flip) begin
      sck_o <= !sck_o;
    end
  end

  chk_master_half_period: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (flip && !abort_i && edges != EDGES_C - 6'h01)
    |=> !flip ##1 (flip || abort_i || $past(abort_i))
  ) else $error("master shift clock half period wrong");

  chk_master_idle_level: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (!busy_o && !start_i && $stable(idle_level_i)) |=> (sck_o == $past(idle_level_i))
  ) else $error("master shift clock not at idle level");

endmodule : ssp_clkgen
`default_nettype wire

// file: core/ssp_shifter.sv
`timescale 1ns/10ps
`default_nettype none
`include "ssp_defines.svh"

module ssp_shifter
  import ssp_pkg::*;
#(
  parameter int WIDTH     = `SSP_BITS,
  parameter bit MSB_FIRST = 1'b1
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  // Shift clock events
  input  wire logic             rise_i,
  input  wire logic             fall_i,
  input  wire logic             idle_level_i,
  input  wire logic             abort_i,
  // Serial lines
  input  wire logic             sdi_i,
  output logic                  sdo_o,
  // Parallel side
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] load_data_i,
  input  wire logic             fill_ones_i,
  output logic [WIDTH-1:0]      data_o,
  output logic                  active_o,
  output logic                  done_o
);

  localparam logic [3:0] LAST_C = 4'(WIDTH - 1);
  localparam logic [3:0] FULL_C = 4'(WIDTH);

  logic [3:0] count;
  logic       in_bit;
  logic       start_edge;
  logic       do_rise;
  logic       do_fall;

  function automatic logic [WIDTH-1:0] shift_in(input logic [WIDTH-1:0] v, input logic b);
    shift_in = MSB_FIRST ? {v[WIDTH-2:0], b} : {b, v[WIDTH-1:1]};
  endfunction : shift_in

  // Last stage drives the pin, so between bytes it shows the first bit taken in
  assign sdo_o      = MSB_FIRST ? data_o[WIDTH-1] : data_o[0];
  assign start_edge = !active_o && (idle_level_i ? fall_i : rise_i);
  assign do_rise    = rise_i && (active_o || start_edge);
  assign do_fall    = fall_i && active_o;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o   <= '0;
      in_bit   <= 1'b0;
      count    <= 4'h0;
      active_o <= 1'b0;
      done_o   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        active_o <= 1'b0;
        count    <= 4'h0;
      end else if (start_edge) begin
        active_o <= 1'b1;
      end
      if (load_i) begin
        data_o <= load_data_i;
      end else if (fill_ones_i) begin
        data_o <= '1;
      end else if (!abort_i && do_rise && count == LAST_C) begin
        data_o <= shift_in(data_o, sdi_i);
      end else if (!abort_i && do_fall && count != 4'h0 && count != FULL_C) begin
        data_o <= shift_in(data_o, in_bit);
      end
      if (!abort_i && do_rise) begin
        in_bit <= sdi_i;
        if (count == LAST_C && idle_level_i) begin
          count    <= 4'h0;
          active_o <= 1'b0;
          done_o   <= 1'b1;
        end else begin
          count <= count + 4'h1;
        end
      end else if (!abort_i && do_fall && count == FULL_C) begin
        count    <= 4'h0;
        active_o <= 1'b0;
        done_o   <= 1'b1;
      end
    end
  end

  chk_eighth_rise_done: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (do_rise && !abort_i && count == LAST_C && idle_level_i) |=> (done_o && !active_o)
  ) else $error("byte not complete at final rising edge");

  chk_count_bounded: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (count <= FULL_C) && (active_o || count == 4'h0 || $past(abort_i))
  ) else $error("bit counter out of range");

endmodule : ssp_shifter
`default_nettype wire

// file: core/ssp_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ssp_defines.svh"

module ssp_top
  import ssp_pkg::*;
#(
  parameter bit MSB_FIRST = 1'b1
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // Avalon-MM slave, byte addressed
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Shift clock pin
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  // Serial data pins
  input  wire logic        serial_in_line_i,
  output logic             serial_out_line_o,
  output logic             serial_out_line_oe_o,
  // Port B coupling
  output logic             port_b_dir_load_o,
  output logic             port_b_bit_five_dir_o,
  output logic             port_b_bit_six_dir_o,
  output logic             port_b_bit_seven_dir_o,
  output logic             simple_serial_port_on_o
);

  logic           rst_meta;
  logic           rst_n;
  ssp_bus_state_t bus_st;
  logic           req;
  logic           acc;
  logic [7:0]     ctrl;
  logic           en;
  logic           mstr;
  logic           idle_clock_level_bit;
  logic           en_d;
  logic           mstr_d;
  logic           abort;
  logic           wr_data;
  logic           data_acc;
  logic           stat_rd;
  logic           armed;
  logic           done_flag;
  logic           clash_flag;
  logic           clear_seq;
  logic           sck_prev;
  logic           s_rise;
  logic           s_fall;
  logic           m_rise;
  logic           m_fall;
  logic           m_sck;
  logic           m_busy;
  logic           m_start;
  logic           rise;
  logic           fall;
  logic [7:0]     shift_data;
  logic           active;
  logic           done;
  logic           serial_out_line;
  logic [7:0]     rd_byte;

  function automatic logic hit(input logic [5:0] a, input logic [3:0] idx);
    hit = (a[5:2] == idx) && (a[1:0] == 2'b00);
  endfunction : hit

  // Reset is released through two flops; assertion stays asynchronous
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // One wait cycle per access so side effects land on the accepted edge
  assign req               = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && (bus_st != SSP_BUS_ACK);
  assign acc               = req && (bus_st == SSP_BUS_ACK);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_st <= SSP_BUS_IDLE;
    end else begin
      case (bus_st)
        SSP_BUS_IDLE: begin
          if (req) begin
            bus_st <= SSP_BUS_ACK;
          end
        end
        SSP_BUS_ACK: bus_st <= SSP_BUS_IDLE;
        default:     bus_st <= SSP_BUS_IDLE;
      endcase
    end
  end

  // Control register
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `SSP_CTRL_RESET;
    end else if (acc && avs_write_i && avs_byteenable_i[0]
                 && hit(avs_address_i, `SSP_IDX_CTRL)) begin
      ctrl <= avs_writedata_i[7:0] & `SSP_CTRL_MASK;
    end
  end

  assign en   = ctrl[`SSP_CTRL_EN];
  assign mstr = ctrl[`SSP_CTRL_MSTR];
  assign idle_clock_level_bit = ctrl[`SSP_CTRL_IDLE_CLOCK_LEVEL_BIT];

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      en_d   <= 1'b0;
      mstr_d <= 1'b0;
    end else begin
      en_d   <= en;
      mstr_d <= mstr;
    end
  end

  // Dropping either enable or master ends a transfer at once
  assign abort = (en_d && !en) || (mstr_d && !mstr);

  // Data register reachable only while enabled
  assign wr_data  = acc && avs_write_i && avs_byteenable_i[0] && en
                    && hit(avs_address_i, `SSP_IDX_DATA);
  assign data_acc = acc && en && hit(avs_address_i, `SSP_IDX_DATA)
                    && (avs_read_i || avs_byteenable_i[0]);
  assign stat_rd  = acc && avs_read_i && hit(avs_address_i, `SSP_IDX_STAT);
  assign m_start  = wr_data && mstr && !active && !m_busy;

  // Shift clock source; slave edges rely on an external rate of at most bus/4
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev <= 1'b1;
    end else begin
      sck_prev <= sck_i;
    end
  end

  assign s_rise = en && !mstr && sck_i && !sck_prev;
  assign s_fall = en && !mstr && !sck_i && sck_prev;
  assign rise   = mstr ? (en && m_rise) : s_rise;
  assign fall   = mstr ? (en && m_fall) : s_fall;

  ssp_clkgen u_clkgen (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n),
    .start_i      (m_start),
    .abort_i      (abort),
    .idle_level_i (idle_clock_level_bit),
    .sck_o        (m_sck),
    .rise_o       (m_rise),
    .fall_o       (m_fall),
    .busy_o       (m_busy)
  );

  // Single register serves transmit and receive; writes overwrite it
  ssp_shifter #(
    .WIDTH     (`SSP_BITS),
    .MSB_FIRST (MSB_FIRST)
  ) u_shifter (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n),
    .rise_i       (rise),
    .fall_i       (fall),
    .idle_level_i (idle_clock_level_bit),
    .abort_i      (abort),
    .sdi_i        (serial_in_line_i),
    .sdo_o        (serial_out_line),
    .load_i       (wr_data),
    .load_data_i  (avs_writedata_i[7:0]),
    .fill_ones_i  (en && !en_d),
    .data_o       (shift_data),
    .active_o     (active),
    .done_o       (done)
  );

  // Clearing needs a status read with done set, then a data access
  assign clear_seq = data_acc && armed;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (data_acc) begin
      armed <= 1'b0;
    end else if (stat_rd && done_flag) begin
      armed <= 1'b1;
    end
  end

  // A new completion wins over a clear in the same cycle
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      done_flag <= 1'b0;
    end else if (done) begin
      done_flag <= 1'b1;
    end else if (clear_seq) begin
      done_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      clash_flag <= 1'b0;
    end else if (data_acc && active && !done) begin
      clash_flag <= 1'b1;
    end else if (clear_seq) begin
      clash_flag <= 1'b0;
    end
  end

  // Read data; data reads during a transfer show the live shift state
  always_comb begin
    rd_byte = 8'h00;
    if (hit(avs_address_i, `SSP_IDX_CTRL)) begin
      rd_byte = ctrl;
    end else if (hit(avs_address_i, `SSP_IDX_STAT)) begin
      rd_byte[`SSP_STAT_DONE]  = done_flag;
      rd_byte[`SSP_STAT_CLASH] = clash_flag;
    end else if (hit(avs_address_i, `SSP_IDX_DATA) && en) begin
      rd_byte = shift_data;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= 32'h0;
    end else if (bus_st == SSP_BUS_IDLE && avs_read_i) begin
      avs_readdata_o <= {24'h0, rd_byte};
    end
  end

  // Pins; output line follows the last shift stage while enabled
  assign serial_out_line_o    = serial_out_line;
  assign serial_out_line_oe_o = en;
  assign sck_o                = m_sck;
  assign sck_oe_o             = en && mstr;

  // Direction load is a pulse so later software changes stand
  assign port_b_dir_load_o       = en && !en_d;
  assign port_b_bit_five_dir_o   = 1'b1;
  assign port_b_bit_six_dir_o    = 1'b0;
  assign port_b_bit_seven_dir_o  = mstr;
  assign simple_serial_port_on_o = en;

  chk_enable_drives_one: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (en && !en_d && !wr_data) |=> (serial_out_line_o && serial_out_line_oe_o)
  ) else $error("output line not high after enable");

  chk_done_sets_flag: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    done |=> done_flag
  ) else $error("done flag not set at final edge");

  chk_clear_sequence: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (stat_rd && done_flag) ##1 (!data_acc && !done)[*2] ##1 (data_acc && !done)
    |=> !done_flag
  ) else $error("done flag survived clear sequence");

  chk_clash_sets: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (data_acc && active && !done) |=> clash_flag
  ) else $error("clash flag not set on mid-transfer access");

  chk_data_gated: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (bus_st == SSP_BUS_IDLE && avs_read_i && !en && hit(avs_address_i, `SSP_IDX_DATA))
    |=> (avs_readdata_o == 32'h0)
  ) else $error("data register readable while disabled");

  chk_disable_aborts: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (en_d && !en) |=> (!active && !m_busy)
  ) else $error("transfer not aborted on disable");

  chk_master_start: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (m_start && !abort) |=> (m_busy && sck_oe_o)
  ) else $error("master write did not start transfer");

endmodule : ssp_top
`default_nettype wire

// file: dv/ssp_ext_device.sv
`timescale 1ns/10ps
`default_nettype none

module ssp_ext_device (
  // Clock
  input  wire logic       mclk_i,
  // Bench control
  input  wire logic       load_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       run_i,
  input  wire logic       idle_level_i,
  input  wire logic [3:0] half_i,
  // Lines
  input  wire logic       line_sck_i,
  input  wire logic       dev_out_i,
  output logic            ext_sck_o,
  output logic            ext_data_o,
  // Observation
  output logic [7:0]      rx_byte_o,
  output logic [3:0]      rise_count_o,
  output logic [3:0]      rise_gap_o
);
  logic [7:0] tx_sr;
  logic       last_sck;
  logic       last_out;
  logic [3:0] hcnt;
  logic [3:0] gap;
  logic [4:0] edges;

  initial begin
    ext_sck_o    = 1'b1;
    ext_data_o   = 1'b0;
    rx_byte_o    = 8'h00;
    rise_count_o = 4'h0;
    rise_gap_o   = 4'h0;
    tx_sr        = 8'h00;
    last_sck     = 1'b1;
    last_out     = 1'b0;
    hcnt         = 4'h0;
    gap          = 4'h0;
    edges        = 5'h00;
  end

  // Clock source when the port is a slave; half_i never below 2 keeps rate at or below mclk/4
  always @(posedge mclk_i) begin
    if (run_i) begin
      edges <= 5'h10;
      hcnt  <= half_i;
    end else if (edges != 5'h00) begin
      if (hcnt == 4'h1) begin
        ext_sck_o <= ~ext_sck_o;
        edges     <= edges - 5'h01;
        hcnt      <= half_i;
      end else begin
        hcnt <= hcnt - 4'h1;
      end
    end else begin
      ext_sck_o <= idle_level_i;
    end
  end

  // Data side: sample on rise, change on fall
  always @(posedge mclk_i) begin
    last_sck <= line_sck_i;
    // Take the line as it stood just before the clock edge, as a real slave would
    last_out <= dev_out_i;
    if (gap != 4'hf) begin
      gap <= gap + 4'h1;
    end
    if (load_i) begin
      tx_sr        <= tx_byte_i;
      ext_data_o   <= tx_byte_i[7];
      rise_count_o <= 4'h0;
    end else begin
      if (line_sck_i && !last_sck) begin
        rx_byte_o    <= {rx_byte_o[6:0], last_out};
        rise_count_o <= rise_count_o + 4'h1;
        rise_gap_o   <= gap;
        gap          <= 4'h1;
      end
      if (!line_sck_i && last_sck && rise_count_o != 4'h0 && rise_count_o < 4'h8) begin
        tx_sr      <= tx_sr << 1;
        ext_data_o <= tx_sr[6];
      end
      // Hold time over: do not leave the last bit looking valid
      if (rise_count_o == 4'h8 && gap == 4'h3) begin
        ext_data_o <= ~ext_data_o;
      end
    end
  end
endmodule : ssp_ext_device

`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ssp_defines.svh"

module tb_top;
  import ssp_pkg::*;
  localparam logic [5:0] A_CTRL = {`SSP_IDX_CTRL, 2'b00};
  localparam logic [5:0] A_STAT = {`SSP_IDX_STAT, 2'b00};
  localparam logic [5:0] A_DATA = {`SSP_IDX_DATA, 2'b00};
  logic        mclk_i, reset_n_i, rd, wr, wreq, sck_o, sck_oe, serial_out_line, sdo_oe;
  logic        dload, d5, d6, d7, port_on, ext_sck, ext_dat, sdo_hold;
  logic        p_load, p_run, p_idle;
  logic [5:0]  adr;
  logic [31:0] wdat, rdat;
  logic [3:0]  be, p_half, p_rises, p_gap;
  logic [7:0]  p_tx, p_rx, s;
  int          bad_count, cmp_count, loads;
  wire         sck_line = sck_oe ? sck_o : ext_sck;
  wire         out_line = sdo_oe ? serial_out_line : sdo_hold;

  ssp_top #(.MSB_FIRST(1'b1)) i_dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .sck_i(sck_line), .sck_o(sck_o),
    .sck_oe_o(sck_oe), .serial_in_line_i(ext_dat), .serial_out_line_o(serial_out_line),
    .serial_out_line_oe_o(sdo_oe), .port_b_dir_load_o(dload), .port_b_bit_five_dir_o(d5),
    .port_b_bit_six_dir_o(d6), .port_b_bit_seven_dir_o(d7), .simple_serial_port_on_o(port_on));

  ssp_ext_device i_partner (
    .mclk_i(mclk_i), .load_i(p_load), .tx_byte_i(p_tx), .run_i(p_run),
    .idle_level_i(p_idle), .half_i(p_half), .line_sck_i(sck_line), .dev_out_i(out_line),
    .ext_sck_o(ext_sck), .ext_data_o(ext_dat), .rx_byte_o(p_rx),
    .rise_count_o(p_rises), .rise_gap_o(p_gap));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // Released output line shows the inverse of its last value
  always @(posedge mclk_i) begin
    if (sdo_oe) sdo_hold <= ~serial_out_line;
    if (dload === 1'b1) loads <= loads + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] b, output logic [7:0] q);
    int n;
    @(posedge mclk_i);
    adr  <= a;
    rd   <= !w;
    wr   <= w;
    wdat <= {24'h000000, d};
    be   <= b;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) check("waitrequest", wreq, 32'h0);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d, input logic [3:0] b);
    logic [7:0] q;
    bus(1'b1, a, d, b, q);
  endtask : wr_reg

  task automatic rd_chk(input string what, input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, 4'hf, q);
    check(what, q, exp);
  endtask : rd_chk

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      bus(1'b0, A_STAT, 8'h00, 4'hf, s);
      n++;
    end while (s[7] !== 1'b1 && n < 100);
    if (n >= 100) check("done wait", s, 32'h80);
  endtask : wait_done

  task automatic wait_rises(input logic [3:0] k);
    int n;
    n = 0;
    while (p_rises < k && n < 200) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 200) check("rise wait", p_rises, {28'h0, k});
  endtask : wait_rises

  task automatic ext_go(input logic [7:0] tx, input logic run, input logic [3:0] h);
    @(posedge mclk_i);
    p_tx   <= tx;
    p_load <= 1'b1;
    p_half <= h;
    @(posedge mclk_i);
    p_load <= 1'b0;
    p_run  <= run;
    @(posedge mclk_i);
    p_run  <= 1'b0;
  endtask : ext_go

  task automatic t_reset();
    rd_chk("ctrl reset", A_CTRL, 8'h04);
    rd_chk("status reset", A_STAT, 8'h00);
    rd_chk("data disabled", A_DATA, 8'h00);
    rd_chk("unmapped", 6'h00, 8'h00);
    wr_reg(A_CTRL, 8'h54, 4'he);
    rd_chk("ctrl no lane", A_CTRL, 8'h04);
    check("idle sck", sck_o, 32'h1);
    check("sck oe reset", sck_oe, 32'h0);
  endtask : t_reset

  task automatic t_master();
    wr_reg(A_CTRL, 8'h54, 4'hf);
    // Fill and load pulse land one edge after the write; read them once settled
    repeat (2) @(posedge mclk_i);
    check("dir loads", loads, 32'h1);
    check("dirs", {d7, d6, d5}, 32'h5);
    check("port on", port_on, 32'h1);
    check("out high", {sdo_oe, serial_out_line}, 32'h3);
    check("sck oe", sck_oe, 32'h1);
    rd_chk("ctrl", A_CTRL, 8'h54);
    ext_go(8'h5a, 1'b0, 4'h2);
    wr_reg(A_DATA, 8'h3c, 4'hf);
    wait_done();
    check("done", s, 32'h80);
    check("far rx", p_rx, 32'h3c);
    check("rises", p_rises, 32'h8);
    check("rate", p_gap, 32'h4);
    rd_chk("rx data", A_DATA, 8'h5a);
    rd_chk("done clear", A_STAT, 8'h00);
    check("idle out", out_line, 32'h0);
    check("idle sck hi", sck_o, 32'h1);
  endtask : t_master

  task automatic t_clash();
    ext_go(8'hc3, 1'b0, 4'h2);
    wr_reg(A_DATA, 8'h81, 4'hf);
    wait_rises(4'h1);
    wr_reg(A_DATA, 8'h18, 4'hf);
    wait_done();
    check("clash", s, 32'hc0);
    check("no restart", p_rises, 32'h8);
    wr_reg(A_DATA, 8'h00, 4'hf);
    rd_chk("clash clear", A_STAT, 8'h00);
    // The clearing write started a byte; let it end so no transfer is left running
    wait_done();
    check("done again", s, 32'h80);
  endtask : t_clash

  task automatic t_abort();
    ext_go(8'h11, 1'b0, 4'h2);
    wr_reg(A_DATA, 8'h22, 4'hf);
    wait_rises(4'h2);
    wr_reg(A_CTRL, 8'h44, 4'hf);
    // Longer than a whole master byte
    repeat (40) @(posedge mclk_i);
    check("abort oe", sck_oe, 32'h0);
    check("abort short", p_rises < 4'h8, 32'h1);
    rd_chk("abort status", A_STAT, 8'h00);
    wr_reg(A_CTRL, 8'h00, 4'hf);
    @(posedge mclk_i);
    check("port off", {port_on, sdo_oe}, 32'h0);
    rd_chk("data off", A_DATA, 8'h00);
  endtask : t_abort

  task automatic t_slave(input logic [3:0] h);
    @(posedge mclk_i);
    p_idle <= 1'b0;
    wr_reg(A_CTRL, 8'h00, 4'hf);
    wr_reg(A_CTRL, 8'h40, 4'hf);
    @(posedge mclk_i);
    check("low idle", sck_o, 32'h0);
    check("slave dirs", {sck_oe, d7}, 32'h0);
    wr_reg(A_DATA, 8'h43, 4'hf);
    @(posedge mclk_i);
    check("first bit waits", serial_out_line, 32'h0);
    ext_go(8'h96, 1'b1, h);
    wait_done();
    check("slave done", s, 32'h80);
    check("slave far rx", p_rx, 32'h43);
    rd_chk("slave rx", A_DATA, 8'h96);
    rd_chk("slave clear", A_STAT, 8'h00);
  endtask : t_slave

  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge mclk_i);
    bad_count++;
    final_report();
  end

  initial begin
    reset_n_i = 1'b0;
    adr       = 6'h00;
    rd        = 1'b0;
    wr        = 1'b0;
    wdat      = 32'h0;
    be        = 4'h0;
    p_load    = 1'b0;
    p_run     = 1'b0;
    p_idle    = 1'b1;
    p_half    = 4'h2;
    p_tx      = 8'h00;
    sdo_hold  = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    loads     = 0;
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    t_reset();
    t_master();
    t_clash();
    t_abort();
    t_slave(4'h2);
    t_slave(4'h5);
    final_report();
  end
endmodule : tb_top

`default_nettype wire
